/* src/irq_gate_consts.svh */
`ifndef IRQ_GATE_CONSTS_SVH
`define IRQ_GATE_CONSTS_SVH

// register offsets
`define LOCAL_IRQ_MASK_OFS         16'h0504
`define LOCAL_IRQ_GLOBAL_ENABLE_OFS 16'h0508
`define HOST_IRQ_MASK_OFS          16'h050c
`define HOST_IRQ_GLOBAL_ENABLE_OFS 16'h0510

// reset values
`define MASK_RESET                 32'h0000_0000
`define ENABLE_RESET               1'h0

// implemented mask bits: 26:16, 9, 7:0
`define MASK_VALID_BITS            32'h07ff_02ff
`define GLOBAL_GATE_BIT            0
`define EXT_PENDING_BIT            25

`endif

/* src/irq_gate_pkg.sv */
package irq_gate_pkg;

	typedef struct packed {
		logic        wr_en;
		logic        rd_en;
		logic [15:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        local_irq;
		logic        host_irq;
	} irq_out_t;

endpackage

/* src/irq_mask_reduce.sv */
`timescale 1ns/1ns
`include "irq_gate_consts.svh"

module irq_mask_reduce #(
	parameter int WIDTH = 32
) (
	// operands
	input  wire logic [WIDTH-1:0] status_vec,
	input  wire logic [WIDTH-1:0] mask_vec,
	input  wire logic             gate,
	// result
	output logic                  irq_level
);

	logic [WIDTH-1:0] hit;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			assign hit[i] = status_vec[i] & mask_vec[i];
		end
	endgenerate

	assign irq_level = gate & (|hit);

endmodule

/* src/pci_irq_mask_enable.sv */
`timescale 1ns/1ns
`include "irq_gate_consts.svh"

// Operation
// - a status bit reaches the local interrupt only while its local mask bit is 1.
// - masks never set or clear any status bit; they only select contributors.
// - bit 0 of the local enable register gates the local interrupt globally.
// - an independent host mask over the same status vector drives the host interrupt.
// - bit 0 of the host enable register gates the host interrupt globally.
// - mask bits 7:0 cover local tx/rx events, bit 9 tx starvation, 8 and 15:10 reserved.
// - mask bits 26:16 cover pci tx/rx, rx starvation, ext pending, abort; 31:27 reserved.
// - every mask and enable bit clears to zero on reset, disabling both outputs.
// - the external pending status bit reads zero while in client mode.
module pci_irq_mask_enable #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   srst,
	// register access
	input  wire irq_gate_pkg::reg_req_t reg_req,
	output logic [WIDTH-1:0]            reg_rdata,
	// status source and mode
	input  wire logic [WIDTH-1:0]       interrupt_status_vector,
	input  wire logic                   host_mode,
	// interrupt indications
	output irq_gate_pkg::irq_out_t      irq_out
);

	logic [WIDTH-1:0]       local_mask_vector_r;
	logic [WIDTH-1:0]       local_mask_vector_nxt;
	logic                   local_global_gate_r;
	logic                   local_global_gate_nxt;
	logic [WIDTH-1:0]       host_mask_vector_r;
	logic [WIDTH-1:0]       host_mask_vector_nxt;
	logic                   host_global_gate_r;
	logic                   host_global_gate_nxt;
	logic [WIDTH-1:0]       rdata_r;
	logic [WIDTH-1:0]       rdata_nxt;
	irq_gate_pkg::irq_out_t irq_r;
	irq_gate_pkg::irq_out_t irq_nxt;
	logic [WIDTH-1:0]       status_eff;
	logic                   local_lvl;
	logic                   host_lvl;

	localparam logic [WIDTH-1:0] VALID = WIDTH'(`MASK_VALID_BITS);

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	// client mode forcing; status is only read, never written
	always_comb
	begin
		status_eff = interrupt_status_vector;
		if (!host_mode)
			status_eff[`EXT_PENDING_BIT] = 1'b0;
	end

	// register writes
	always_comb
	begin
		local_mask_vector_nxt = local_mask_vector_r;
		local_global_gate_nxt = local_global_gate_r;
		host_mask_vector_nxt  = host_mask_vector_r;
		host_global_gate_nxt  = host_global_gate_r;
		if (reg_req.wr_en)
		begin
			if (hit(reg_req.addr, `LOCAL_IRQ_MASK_OFS))
				local_mask_vector_nxt = reg_req.wdata[WIDTH-1:0] & VALID;
			if (hit(reg_req.addr, `LOCAL_IRQ_GLOBAL_ENABLE_OFS))
				local_global_gate_nxt = reg_req.wdata[`GLOBAL_GATE_BIT];
			if (hit(reg_req.addr, `HOST_IRQ_MASK_OFS))
				host_mask_vector_nxt = reg_req.wdata[WIDTH-1:0] & VALID;
			if (hit(reg_req.addr, `HOST_IRQ_GLOBAL_ENABLE_OFS))
				host_global_gate_nxt = reg_req.wdata[`GLOBAL_GATE_BIT];
		end
	end

	// read data, registered; unmapped reads return zero
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (reg_req.rd_en)
		begin
			rdata_nxt = '0;
			if (hit(reg_req.addr, `LOCAL_IRQ_MASK_OFS))
				rdata_nxt = local_mask_vector_r;
			else if (hit(reg_req.addr, `LOCAL_IRQ_GLOBAL_ENABLE_OFS))
				rdata_nxt[0] = local_global_gate_r;
			else if (hit(reg_req.addr, `HOST_IRQ_MASK_OFS))
				rdata_nxt = host_mask_vector_r;
			else if (hit(reg_req.addr, `HOST_IRQ_GLOBAL_ENABLE_OFS))
				rdata_nxt[0] = host_global_gate_r;
		end
	end

	irq_mask_reduce #(
		.WIDTH      (WIDTH)
	) u_local (
		.status_vec (status_eff),
		.mask_vec   (local_mask_vector_r & VALID),
		.gate       (local_global_gate_r),
		.irq_level  (local_lvl)
	);

	irq_mask_reduce #(
		.WIDTH      (WIDTH)
	) u_host (
		.status_vec (status_eff),
		.mask_vec   (host_mask_vector_r & VALID),
		.gate       (host_global_gate_r),
		.irq_level  (host_lvl)
	);

	// outputs registered, one cycle behind status
	always_comb
	begin
		irq_nxt.local_irq = local_lvl;
		irq_nxt.host_irq  = host_lvl;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			local_mask_vector_r <= WIDTH'(`MASK_RESET);
			local_global_gate_r <= `ENABLE_RESET;
			host_mask_vector_r  <= WIDTH'(`MASK_RESET);
			host_global_gate_r  <= `ENABLE_RESET;
			rdata_r             <= '0;
			irq_r               <= '0;
		end
		else
		begin
			local_mask_vector_r <= local_mask_vector_nxt;
			local_global_gate_r <= local_global_gate_nxt;
			host_mask_vector_r  <= host_mask_vector_nxt;
			host_global_gate_r  <= host_global_gate_nxt;
			rdata_r             <= rdata_nxt;
			irq_r               <= irq_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq_out   = irq_r;

endmodule

/* testbench/irq_gate_asserts.sv */
`timescale 1ns/1ns
module irq_gate_asserts (
	// top ports
	input wire logic                   sys_clk,
	input wire logic                   srst,
	input wire irq_gate_pkg::reg_req_t reg_req,
	input wire logic [31:0]            reg_rdata,
	input wire logic [31:0]            interrupt_status_vector,
	input wire logic                   host_mode,
	input wire irq_gate_pkg::irq_out_t irq_out
);
	logic [31:0] lm, hm, se, rx;
	logic        le, he;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// client mode hides the external pending source
	assign se = interrupt_status_vector & ~{6'h0, !host_mode, 25'h0};
	assign rx = reg_req.addr == 16'h0504 ? lm : reg_req.addr == 16'h0508 ? {31'h0, le} :
		reg_req.addr == 16'h050c ? hm : reg_req.addr == 16'h0510 ? {31'h0, he} : 32'h0;
	always_ff @(posedge sys_clk)
		if (srst)
			{lm, hm, le, he} <= '0;
		else if (reg_req.wr_en)
			case (reg_req.addr)
			16'h0504: lm <= reg_req.wdata & 32'h07ff02ff;
			16'h0508: le <= reg_req.wdata[0];
			16'h050c: hm <= reg_req.wdata & 32'h07ff02ff;
			16'h0510: he <= reg_req.wdata[0];
			default: ;
			endcase
	local_level_a: assert property (1 |=> irq_out.local_irq == $past(le && |(se & lm)))
		else $error("local irq");
	host_level_a: assert property (1 |=> irq_out.host_irq == $past(he && |(se & hm)))
		else $error("host irq");
	local_gate_a: assert property (!le |=> !irq_out.local_irq)
		else $error("local gate");
	host_gate_a: assert property (!he |=> !irq_out.host_irq)
		else $error("host gate");
	reset_clear_a: assert property (disable iff (1'b0) srst |=>
		irq_out == 2'h0 && reg_rdata == 32'h0) else $error("reset");
	read_back_a: assert property (reg_req.rd_en |=> reg_rdata == $past(rx))
		else $error("read data");
	reserved_zero_a: assert property (reg_req.rd_en |=> (reg_rdata & ~32'h07ff02ff) == 0)
		else $error("reserved bits");
	client_ext_a: assert property (!host_mode && interrupt_status_vector == 32'h02000000 |=>
		irq_out == 2'h0) else $error("client pending");
endmodule
bind pci_irq_mask_enable irq_gate_asserts i_irq_gate_asserts (.sys_clk, .srst, .reg_req,
	.reg_rdata, .interrupt_status_vector, .host_mode, .irq_out);

/* testbench/irq_sink.sv */
`timescale 1ns/1ns
module irq_sink (
	// levels in, sampled view out
	input  wire logic                   sys_clk,
	input  wire irq_gate_pkg::irq_out_t irq_out,
	output logic [1:0]                  seen
);
	// level receivers: no latching, a dropped level is seen dropped
	always_ff @(posedge sys_clk)
		seen <= irq_out;
endmodule

/* testbench/pci_irq_mask_enable_tb.sv */
`timescale 1ns/1ns
module pci_irq_mask_enable_tb;
	logic                   sys_clk, srst, host_mode;
	logic [31:0]            reg_rdata, stat;
	logic [1:0]             seen;
	int                     n_errors, tests_run, cyc;
	irq_gate_pkg::reg_req_t reg_req;
	irq_gate_pkg::irq_out_t irq_out;
	pci_irq_mask_enable i_pci_irq_mask_enable (.sys_clk, .srst, .reg_req, .reg_rdata,
		.interrupt_status_vector(stat), .host_mode, .irq_out);
	irq_sink i_irq_sink (.sys_clk, .irq_out, .seen);
	task summarize();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk) reg_req <= '0;
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge sys_clk) reg_req <= '0;
		#1 chk(reg_rdata, e);
	endtask
	task irqs(input logic [31:0] s, input logic h, input logic [31:0] e);
		@(posedge sys_clk)
		begin
			stat <= s;
			host_mode <= h;
		end
		repeat (3) @(posedge sys_clk);
		#1 chk(32'(seen), e);
	endtask
	task t_regs();
		rd(16'h0504, 32'h0);
		rd(16'h0510, 32'h0);
		wr(16'h0504, '1);
		wr(16'h0508, '1);
		wr(16'h0514, '1);
		rd(16'h0504, 32'h07ff02ff);
		rd(16'h0508, 32'h1);
		rd(16'h0514, 32'h0);
		wr(16'h050c, '1);
		rd(16'h050c, 32'h07ff02ff);
		rd(16'h0504, 32'h07ff02ff);
	endtask
	task t_local();
		irqs(32'h100, 0, 32'h0);
		wr(16'h0504, 32'h1);
		irqs(32'h2, 0, 32'h0);
		irqs(32'h1, 0, 32'h2);
		wr(16'h0508, 32'h0);
		irqs(32'h1, 0, 32'h0);
	endtask
	task t_host();
		wr(16'h050c, 32'h02000000);
		wr(16'h0510, 32'h1);
		irqs(32'h02000000, 0, 32'h0);
		irqs(32'h02000000, 1, 32'h1);
		wr(16'h0510, 32'h0);
		irqs(32'h02000000, 1, 32'h0);
	endtask
	task t_rerun();
		wr(16'h0510, 32'h1);
		@(posedge sys_clk) srst <= 1'b1;
		@(posedge sys_clk) srst <= 1'b0;
		irqs(32'h02000000, 1, 32'h0);
		rd(16'h050c, 32'h0);
	endtask
	initial
	begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// bound far above the fewer than a hundred cycles the scenarios need
	always @(posedge sys_clk)
		if (++cyc == 3000)
		begin
			n_errors++;
			summarize();
		end
	initial
	begin
		{srst, reg_req, stat, host_mode} = {1'b1, 50'h0, 32'h0, 1'b0};
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs();
		t_local();
		t_host();
		t_rerun();
		summarize();
	end
endmodule
